// File: hw/host_bus_pkg.sv
// Constants shared by the host bus write port and its interrupt hub.
// Assumes host addresses are halfword addresses A[9:1].
package host_bus_pkg;
    localparam int ADDR_W = 9;
    localparam int DATA_W = 16;
    localparam int IRQ_SRC_N = 9;
    localparam int PIN_W = 2 + 2 + ADDR_W + DATA_W;
    // Synchroniser idle: strobes released, everything else low
    localparam logic [PIN_W-1:0] PIN_IDLE = {2'b11, 27'h0000000};
    // Word indexes (byte address / 4) of the 32-bit registers
    localparam logic [7:0] TX_WIN_IDX_HI = 8'h08;
    localparam logic [7:0] TX_WIN_IDX_LO = 8'h0f;
    localparam logic [7:0] IRQ_CFG_IDX = 8'h10;
    localparam logic [7:0] INTERRUPT_STATUS_REG_IDX = 8'h11;
    localparam logic [7:0] INT_EN_IDX = 8'h12;
    localparam logic [7:0] HW_SETUP_IDX = 8'h13;
    localparam logic [7:0] MAC_CMD_IDX = 8'h14;
    localparam logic [7:0] MAC_DATA_IDX = 8'h15;
    // Reset values
    localparam logic [31:0] IRQ_CFG_RESET = 32'h00000000;
    localparam logic [31:0] HW_SETUP_RESET = 32'h00050000;
    localparam logic [31:0] MAC_REG_RESET = 32'h00000000;
    // Field positions
    localparam int CFG_TYPE_BIT = 0;
    localparam int CFG_POL_BIT = 4;
    localparam int CFG_EN_BIT = 8;
    localparam int CFG_DEAS_LSB = 24;
    localparam int MAC_BUSY_BIT = 31;
    localparam int HW_ALLOC_LSB = 16;
    // Cycles of clk_sys per step of the deassertion interval field
    localparam int DEAS_UNIT_CYC = 16;
    typedef enum logic [1:0] {
        IRQ_WR_CFG,
        IRQ_WR_STS,
        IRQ_WR_EN
    } irq_reg_type;
endpackage : host_bus_pkg

// File: hw/host_bus_write_port.sv
// Write side of the 16-bit asynchronous host bus port.
// Assumes host pins are asynchronous to clk_sys and the TX data FIFO,
// MAC register bridge and interrupt sources sit on clk_sys.
`timescale 1ns/1ps
module host_bus_write_port (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic chip_select_n,
    input wire logic write_strobe_n,
    input wire logic byte_order_sel,
    input wire logic fifo_direct_sel,
    input wire logic [host_bus_pkg::ADDR_W:1] host_addr,
    input wire logic [host_bus_pkg::DATA_W-1:0] host_data,
    input wire logic [host_bus_pkg::IRQ_SRC_N-1:0] irq_sources,
    output logic [host_bus_pkg::IRQ_SRC_N-1:0] int_status,
    output logic irq_out,
    output logic irq_oe_n,
    output logic tx_data_valid,
    input wire logic tx_data_ready,
    output logic [host_bus_pkg::DATA_W-1:0] tx_data,
    output logic [1:0] tx_data_lane,
    output logic tx_overrun,
    output logic [31:0] hardware_setup,
    output logic mac_cmd_valid,
    input wire logic mac_cmd_done,
    output logic [31:0] mac_cmd,
    output logic [31:0] mac_wdata
);
    import host_bus_pkg::*;

    function automatic logic word_hit(input logic [7:0] idx, input logic [7:0] reg_idx);
        word_hit = (idx == reg_idx);
    endfunction : word_hit

    function automatic logic [31:0] put_half(input logic [31:0] old, input logic high,
                                             input logic [15:0] value);
        put_half = high ? {value, old[15:0]} : {old[31:16], value};
    endfunction : put_half

    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] pin_meta;
    logic [PIN_W-1:0] pin_sync;
    logic cs_n_s;
    logic wr_n_s;
    logic cycle_on;
    logic cycle_q;
    logic cycle_end;
    logic [ADDR_W:1] cap_addr;
    logic [DATA_W-1:0] cap_data;
    logic cap_order;
    logic cap_fifo;
    logic [DATA_W-1:0] ordered;
    logic [7:0] word_idx;
    logic half_high;
    logic fifo_hit;
    logic reg_write;
    logic hit_cfg;
    logic hit_sts;
    logic hit_en;
    logic hit_setup;
    logic hit_cmd;
    logic hit_mdata;
    logic cmd_start;
    logic mac_busy;

    irq_ctrl_if irq_bus ();

    // All host pins are asynchronous, so each passes two flops first
    assign pin_raw = {chip_select_n, write_strobe_n, byte_order_sel, fifo_direct_sel,
                      host_addr, host_data};

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pin_meta <= PIN_IDLE;
            pin_sync <= PIN_IDLE;
        end else if (ce) begin
            pin_meta <= pin_raw;
            pin_sync <= pin_meta;
        end
    end

    assign cs_n_s = pin_sync[PIN_W-1];
    assign wr_n_s = pin_sync[PIN_W-2];
    // Symmetric AND makes strobe order irrelevant
    assign cycle_on = ~cs_n_s & ~wr_n_s;
    // A recovery gap shorter than one clock may be missed entirely
    assign cycle_end = cycle_q & ~cycle_on;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cycle_q <= 1'b0;
        end else if (ce) begin
            cycle_q <= cycle_on;
        end
    end

    // Keep the last values seen inside the cycle; data may settle late
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cap_addr <= '0;
            cap_data <= '0;
            cap_order <= 1'b0;
            cap_fifo <= 1'b0;
        end else if (ce && cycle_on) begin
            cap_addr <= pin_sync[DATA_W+ADDR_W-1:DATA_W];
            cap_data <= pin_sync[DATA_W-1:0];
            cap_order <= pin_sync[PIN_W-3];
            cap_fifo <= pin_sync[PIN_W-4];
        end
    end

    assign ordered = cap_order ? {cap_data[7:0], cap_data[15:8]} : cap_data;
    assign word_idx = cap_addr[ADDR_W:2];
    assign half_high = cap_addr[1];
    // Direct mode ignores A[9:3]; tie the select high to keep bursts here
    assign fifo_hit = cap_fifo | (word_idx >= TX_WIN_IDX_HI && word_idx <= TX_WIN_IDX_LO);
    assign reg_write = cycle_end & ~fifo_hit;
    assign hit_cfg = word_hit(word_idx, IRQ_CFG_IDX);
    assign hit_sts = word_hit(word_idx, INTERRUPT_STATUS_REG_IDX);
    assign hit_en = word_hit(word_idx, INT_EN_IDX);
    assign hit_setup = word_hit(word_idx, HW_SETUP_IDX);
    assign hit_cmd = word_hit(word_idx, MAC_CMD_IDX);
    assign hit_mdata = word_hit(word_idx, MAC_DATA_IDX);
    // High half carries the busy bit, which launches the MAC access
    assign cmd_start = reg_write & hit_cmd & half_high & ordered[MAC_BUSY_BIT-16] & ~mac_busy;

    // TX data word stream; the lane is A[2:1] in both modes
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            tx_data_valid <= 1'b0;
            tx_data <= '0;
            tx_data_lane <= 2'b00;
            tx_overrun <= 1'b0;
        end else if (ce) begin
            tx_overrun <= cycle_end & fifo_hit & tx_data_valid & ~tx_data_ready;
            if (cycle_end && fifo_hit && (!tx_data_valid || tx_data_ready)) begin
                tx_data_valid <= 1'b1;
                tx_data <= ordered;
                tx_data_lane <= cap_addr[2:1];
            end else if (tx_data_ready) begin
                tx_data_valid <= 1'b0;
            end
        end
    end

    // Setup register steers the shared 16KB store split
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            hardware_setup <= HW_SETUP_RESET;
        end else if (ce && reg_write && hit_setup) begin
            hardware_setup <= put_half(hardware_setup, half_high, ordered);
        end
    end

    // MAC registers are reached only through command and data
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            mac_cmd <= MAC_REG_RESET;
            mac_wdata <= MAC_REG_RESET;
            mac_cmd_valid <= 1'b0;
            mac_busy <= 1'b0;
        end else if (ce) begin
            mac_cmd_valid <= cmd_start;
            if (reg_write && hit_cmd && !mac_busy) begin
                mac_cmd <= put_half(mac_cmd, half_high, ordered);
            end
            if (reg_write && hit_mdata && !mac_busy) begin
                mac_wdata <= put_half(mac_wdata, half_high, ordered);
            end
            // Start wins over a done that lands in the same cycle
            if (cmd_start) begin
                mac_busy <= 1'b1;
            end else if (mac_cmd_done) begin
                mac_busy <= 1'b0;
            end
        end
    end

    assign irq_bus.wr_en = reg_write & (hit_cfg | hit_sts | hit_en);
    assign irq_bus.wr_reg = hit_cfg ? IRQ_WR_CFG : (hit_sts ? IRQ_WR_STS : IRQ_WR_EN);
    assign irq_bus.wr_high = half_high;
    assign irq_bus.wr_data = ordered;
    assign int_status = irq_bus.status;

    irq_hub u_irq_hub (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ce(ce),
        .regs(irq_bus.hub),
        .sources(irq_sources),
        .irq_out(irq_out),
        .irq_oe_n(irq_oe_n)
    );
endmodule : host_bus_write_port

// File: hw/irq_ctrl_if.sv
// Carries interrupt register writes and state between the write port and hub.
// Assumes both ends share clk_sys.
`timescale 1ns/1ps
interface irq_ctrl_if;
    import host_bus_pkg::*;
    logic wr_en;
    irq_reg_type wr_reg;
    logic wr_high;
    logic [DATA_W-1:0] wr_data;
    logic [IRQ_SRC_N-1:0] status;
    modport hub (input wr_en, input wr_reg, input wr_high, input wr_data, output status);
    modport core (output wr_en, output wr_reg, output wr_high, output wr_data, input status);
endinterface : irq_ctrl_if

// File: hw/irq_hub.sv
// Top-level interrupt configuration, status and enable registers.
// Assumes sources are levels from logic on clk_sys.
`timescale 1ns/1ps
module irq_hub (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    irq_ctrl_if.hub regs,
    input wire logic [host_bus_pkg::IRQ_SRC_N-1:0] sources,
    output logic irq_out,
    output logic irq_oe_n
);
    import host_bus_pkg::*;
    logic [31:0] cfg;
    logic [IRQ_SRC_N-1:0] sts;
    logic [IRQ_SRC_N-1:0] en;
    logic [IRQ_SRC_N-1:0] clr;
    logic [IRQ_SRC_N-1:0] next_sts;
    logic active;
    logic pending;
    logic [15:0] deas_cnt;
    wire wr_low = regs.wr_en & ~regs.wr_high;

    assign clr = (wr_low && regs.wr_reg == IRQ_WR_STS) ? regs.wr_data[IRQ_SRC_N-1:0] : '0;
    // Source still high in the clearing cycle keeps its bit
    assign next_sts = (sts & ~clr) | sources;
    assign pending = cfg[CFG_EN_BIT] & (|(sts & en));
    assign regs.status = sts;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cfg <= IRQ_CFG_RESET;
            sts <= '0;
            en <= '0;
        end else if (ce) begin
            sts <= next_sts;
            if (regs.wr_en && regs.wr_reg == IRQ_WR_CFG) begin
                if (regs.wr_high) begin
                    cfg[31:16] <= regs.wr_data;
                end else begin
                    cfg[15:0] <= regs.wr_data;
                end
            end
            if (wr_low && regs.wr_reg == IRQ_WR_EN) begin
                en <= regs.wr_data[IRQ_SRC_N-1:0];
            end
        end
    end

    // Once released, the line stays quiet for the programmed interval
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            active <= 1'b0;
            deas_cnt <= 16'h0000;
        end else if (ce) begin
            if (active && !pending) begin
                active <= 1'b0;
                deas_cnt <= 16'(cfg[31:CFG_DEAS_LSB] * DEAS_UNIT_CYC);
            end else if (deas_cnt != 16'h0000) begin
                deas_cnt <= deas_cnt - 16'h0001;
            end else begin
                active <= pending;
            end
        end
    end

    // Open drain drives only while asserted; push-pull always drives
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            // Idle level of the default low polarity, so reset never looks like a request
            irq_out <= 1'b1;
            irq_oe_n <= 1'b0;
        end else if (ce) begin
            irq_out <= active ~^ cfg[CFG_POL_BIT];
            irq_oe_n <= ~cfg[CFG_TYPE_BIT] ? 1'b0 : ~active;
        end
    end
endmodule : irq_hub

// File: tb/host_bus_write_port_assertions.sv
// Pin-level checks on the host bus write port.
// Assumes one clk_sys domain with synchronous active-low rst_n.
`timescale 1ns/1ps
module host_bus_write_port_assertions (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic chip_select_n,
    input wire logic write_strobe_n,
    input wire logic [host_bus_pkg::IRQ_SRC_N-1:0] irq_sources,
    input wire logic [host_bus_pkg::IRQ_SRC_N-1:0] int_status,
    input wire logic tx_data_valid,
    input wire logic tx_data_ready,
    input wire logic [host_bus_pkg::DATA_W-1:0] tx_data,
    input wire logic tx_overrun,
    input wire logic [31:0] hardware_setup,
    input wire logic mac_cmd_valid,
    input wire logic [31:0] mac_cmd
);
    import host_bus_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // Eight quiet samples outlast the two-flop sync plus the commit edge
    wire quiet = chip_select_n | write_strobe_n;
    AST_WORD_HELD: assert property (
        tx_data_valid && !tx_data_ready |=> tx_data_valid && $stable(tx_data))
        else $error("tx word changed while waiting");
    AST_DROP_CAUSE: assert property (
        tx_overrun |-> $past(tx_data_valid) && !$past(tx_data_ready))
        else $error("overrun without a waiting word");
    AST_DROP_PULSE: assert property (tx_overrun |=> !tx_overrun)
        else $error("overrun longer than one cycle");
    AST_MAC_PULSE: assert property (mac_cmd_valid |=> !mac_cmd_valid)
        else $error("mac start longer than one cycle");
    AST_MAC_GO: assert property (mac_cmd_valid |-> mac_cmd[31])
        else $error("mac start without go bit");
    AST_QUIET_FIFO: assert property (quiet [*8] |=> !$rose(tx_data_valid))
        else $error("tx word without a write cycle");
    AST_QUIET_REGS: assert property (quiet [*8] |=> $stable(hardware_setup))
        else $error("setup changed without a write cycle");
    AST_STATUS_SETS: assert property (
        ce |=> (int_status & $past(irq_sources)) == $past(irq_sources))
        else $error("status bit missed a source");
    cover property (tx_overrun);
    cover property ($rose(tx_data_valid));
    cover property (mac_cmd_valid);
endmodule : host_bus_write_port_assertions
bind host_bus_write_port host_bus_write_port_assertions u_host_bus_write_port_assertions (
    .clk_sys, .rst_n, .ce, .chip_select_n, .write_strobe_n, .irq_sources, .int_status,
    .tx_data_valid, .tx_data_ready, .tx_data, .tx_overrun, .hardware_setup,
    .mac_cmd_valid, .mac_cmd);

// File: tb/host_bus_write_port_tb_top.sv
// Self-checking bench for the host bus write port.
// Assumes the host model drives the pins; the bench plays TX FIFO and MAC.
`timescale 1ns/1ps
module host_bus_write_port_tb_top;
    import host_bus_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic tx_data_ready = 1'b0;
    logic mac_cmd_done = 1'b0;
    logic [IRQ_SRC_N-1:0] irq_sources = '0;
    wire chip_select_n, write_strobe_n, byte_order_sel, fifo_direct_sel;
    wire [ADDR_W:1] host_addr;
    wire [DATA_W-1:0] host_data, tx_data;
    wire [IRQ_SRC_N-1:0] int_status;
    wire irq_out, irq_oe_n, tx_data_valid, tx_overrun, mac_cmd_valid;
    wire [1:0] tx_data_lane;
    wire [31:0] hardware_setup, mac_cmd, mac_wdata;
    int errors = 0;
    int comparisons = 0;
    int drops = 0;
    int starts = 0;
    host_bus_write_port u_host_bus_write_port (.clk_sys, .rst_n, .ce, .chip_select_n,
        .write_strobe_n, .byte_order_sel, .fifo_direct_sel, .host_addr, .host_data,
        .irq_sources, .int_status, .irq_out, .irq_oe_n, .tx_data_valid, .tx_data_ready,
        .tx_data, .tx_data_lane, .tx_overrun, .hardware_setup, .mac_cmd_valid,
        .mac_cmd_done, .mac_cmd, .mac_wdata);
    host_cpu_model u_host_cpu_model (.clk_sys, .chip_select_n, .write_strobe_n,
        .byte_order_sel, .fifo_direct_sel, .host_addr, .host_data);
    initial forever #2.5 clk_sys = ~clk_sys;
    // One-cycle pulses are counted here so no check can miss them
    always @(posedge clk_sys) begin
        drops <= drops + int'(tx_overrun === 1'b1);
        starts <= starts + int'(mac_cmd_valid === 1'b1);
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic report_and_stop();
        if (errors == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : report_and_stop
    task automatic wr(input logic [ADDR_W:1] a, input logic [DATA_W-1:0] d);
        u_host_cpu_model.write(a, d, 1'b0, 1'b0, 1'b0);
    endtask : wr
    task automatic wait_irq(input logic lvl);
        for (int n = 0; n < 50 && irq_out !== lvl; n++) begin
            @(posedge clk_sys);
            #1;
        end
        chk(irq_out, lvl);
        if (irq_out !== lvl)
            report_and_stop();
    endtask : wait_irq
    task automatic t_reset();
        chk(hardware_setup, 32'h00050000);
        chk({irq_out, irq_oe_n, tx_data_valid, mac_cmd_valid}, 4'b1000);
    endtask : t_reset
    task automatic t_fifo();
        u_host_cpu_model.write(9'h26, 16'h1234, 1'b1, 1'b1, 1'b1);
        chk({tx_data_valid, tx_data_lane, tx_data}, 19'h63412);
        chk(hardware_setup, 32'h00050000);
        u_host_cpu_model.write(9'h155, 16'h5a5a, 1'b1, 1'b0, 1'b0);
        chk(drops, 1);
        chk(tx_data, 16'h3412);
        tx_data_ready = 1'b1;
        @(posedge clk_sys);
        #1;
        chk(tx_data_valid, 1'b0);
        tx_data_ready = 1'b0;
        u_host_cpu_model.write(9'h155, 16'h5a5a, 1'b1, 1'b0, 1'b0);
        chk({tx_data_valid, tx_data_lane, tx_data}, 19'h55a5a);
        tx_data_ready = 1'b1;
    endtask : t_fifo
    task automatic t_mac();
        wr(9'h2a, 16'habcd);
        u_host_cpu_model.write(9'h2b, 16'h0102, 1'b0, 1'b0, 1'b1);
        chk(mac_wdata, 32'h0102abcd);
        wr(9'h1f0, 16'hffff);
        chk(hardware_setup, 32'h00050000);
        wr(9'h28, 16'h0042);
        wr(9'h29, 16'h8001);
        chk(starts, 1);
        chk(mac_cmd, 32'h80010042);
        wr(9'h2a, 16'h1111);
        chk(mac_wdata, 32'h0102abcd);
        mac_cmd_done = 1'b1;
        @(posedge clk_sys);
        #1;
        mac_cmd_done = 1'b0;
        wr(9'h29, 16'h8002);
        chk(starts, 2);
    endtask : t_mac
    task automatic t_irq();
        for (int i = 0; i < IRQ_SRC_N; i++) begin
            irq_sources[i] = 1'b1;
            @(posedge clk_sys);
            #1;
            chk(int_status[i], 1'b1);
            irq_sources[i] = 1'b0;
        end
        wr(9'h24, 16'h0001);
        wr(9'h20, 16'h0100);
        wait_irq(1'b0);
        chk(irq_oe_n, 1'b0);
        wr(9'h20, 16'h0111);
        wait_irq(1'b1);
        chk(irq_oe_n, 1'b0);
        // Interval of one step: the line stays quiet for 16 cycles after release
        wr(9'h21, 16'h0100);
        wr(9'h22, 16'h0001);
        chk(irq_out, 1'b0);
        irq_sources[0] = 1'b1;
        @(posedge clk_sys);
        #1;
        irq_sources[0] = 1'b0;
        repeat (8) @(posedge clk_sys);
        #1;
        chk({irq_out, int_status[0]}, 2'b01);
        wait_irq(1'b1);
        wr(9'h22, 16'h01ff);
        wait_irq(1'b0);
        chk({irq_oe_n, int_status}, 10'h200);
    endtask : t_irq
    // Clock enable low must freeze the status register too
    task automatic t_freeze();
        ce = 1'b0;
        irq_sources[3] = 1'b1;
        repeat (3) @(posedge clk_sys);
        #1;
        chk(int_status, 9'h000);
        ce = 1'b1;
        @(posedge clk_sys);
        #1;
        irq_sources[3] = 1'b0;
        chk(int_status, 9'h008);
        wr(9'h22, 16'h0008);
        chk(int_status, 9'h000);
    endtask : t_freeze
    initial begin
        repeat (4) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        @(posedge clk_sys);
        #1;
        t_reset();
        t_fifo();
        t_mac();
        t_irq();
        t_freeze();
        report_and_stop();
    end
    initial begin
        #100000;
        errors++;
        report_and_stop();
    end
endmodule : host_bus_write_port_tb_top

// File: tb/host_cpu_model.sv
// Host processor model running asynchronous write cycles on the pins.
// Assumes write() is called just after a clk_sys rising edge.
`timescale 1ns/1ps
module host_cpu_model (
    input wire logic clk_sys,
    output logic chip_select_n,
    output logic write_strobe_n,
    output logic byte_order_sel,
    output logic fifo_direct_sel,
    output logic [host_bus_pkg::ADDR_W:1] host_addr,
    output logic [host_bus_pkg::DATA_W-1:0] host_data
);
    import host_bus_pkg::*;
    initial begin
        {chip_select_n, write_strobe_n, byte_order_sel, fifo_direct_sel} = 4'b1100;
        host_addr = '0;
        host_data = '0;
    end
    // Four cycles per phase, one above the three the port needs
    task automatic write(input logic [ADDR_W:1] a, input logic [DATA_W-1:0] d,
        input logic fifo, input logic swap, input logic cs_first);
        host_addr = a;
        host_data = d;
        fifo_direct_sel = fifo;
        byte_order_sel = swap;
        {chip_select_n, write_strobe_n} = cs_first ? 2'b01 : 2'b10;
        @(posedge clk_sys);
        #1;
        {chip_select_n, write_strobe_n} = 2'b00;
        repeat (4) @(posedge clk_sys);
        #1;
        {chip_select_n, write_strobe_n} = cs_first ? 2'b01 : 2'b10;
        @(posedge clk_sys);
        #1;
        {chip_select_n, write_strobe_n} = 2'b11;
        // Released bus: stale values must not be trusted
        host_data = ~d;
        host_addr = ~a;
        repeat (4) @(posedge clk_sys);
        #1;
    endtask : write
endmodule : host_cpu_model
